// ### design/bcdc_pkg.sv
package bcdc_pkg;

  // Register address and control bit positions.
  localparam logic [31:0] BCDC_CTRL_ADDR   = 32'h0000_01D9;
  localparam int          BCDC_CTRL_W      = 64;
  localparam int          BIT_REC_EN       = 0;
  localparam int          BIT_STEP_BRANCH  = 1;
  localparam int          BIT_MSG_EN       = 6;
  localparam int          BIT_STORE_EN     = 7;
  localparam int          BIT_STORE_IRQ    = 8;
  localparam int          BIT_SKIP_PRIV    = 9;
  localparam int          BIT_SKIP_USER    = 10;
  localparam int          BIT_HOLD_REC     = 11;
  localparam int          BIT_HOLD_CNT     = 12;
  localparam int          BIT_HOLD_MGMT    = 14;
  localparam int          BIT_TX_DEBUG     = 15;

  // Masks and reset value of the control register.
  localparam logic [63:0] CTRL_RESET       = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CTRL_WR_MASK     = 64'h0000_0000_0000_DFC3;
  localparam logic [63:0] CTRL_DBG_CLR     = 64'h0000_0000_0000_0003;
  localparam logic [63:0] CTRL_MGMT_CLR    = 64'h0000_0000_0000_00C3;
  localparam logic [1:0]  PRIV_KERNEL      = 2'h0;

  // Management-mode tracking, one-hot.
  typedef enum logic [1:0] {
    MODE_RUN  = 2'b01,
    MODE_HELD = 2'b10
  } bcdc_mode_e;

  // Core events, each a one-cycle pulse or a qualifier of one.
  typedef struct packed {
    logic branchTaken;
    logic intrTaken;
    logic excTaken;
    logic excIsDebug;
    logic instrRetire;
    logic instrIsBranch;
    logic debugExcRaise;
  } bcdc_evt_s;

  // One-cycle requests issued to the rest of the core.
  typedef struct packed {
    logic recordPush;
    logic traceMsgSend;
    logic traceStoreWrite;
    logic traceStoreIrq;
    logic traceStoreWrap;
    logic stepTrapReq;
    logic counterEnClear;
    logic counterEnSet;
    logic wlcHistoryReset;
    logic txResumeAtBegin;
    logic txDebugExcReq;
    logic txFallback;
  } bcdc_pulse_s;

endpackage

// ### design/bcdc_pulse_reg.sv
`timescale 1ns/1ps
// Registers a vector of next values so every request leaves on a flop edge.
module bcdc_pulse_reg #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk, // Core clock.
  input  wire logic             nrst,     // Synchronous reset, active low.
  input  wire logic [WIDTH-1:0] dIn,      // Next value.
  output logic      [WIDTH-1:0] qOut      // Registered value.
);

  ////////////////////////////////////////////////////////////////////////
  // Plain register, cleared to zero so no request leaks out of reset.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      qOut <= '0;
    end else begin
      qOut <= dIn;
    end
  end

endmodule // bcdc_pulse_reg

// ### design/bcdc_save_store.sv
`timescale 1ns/1ps
// Holds the control word captured on management-mode entry.
module bcdc_save_store #(
  parameter int WIDTH = 64
) (
  input  wire logic             core_clk, // Core clock.
  input  wire logic             nrst,     // Synchronous reset, active low.
  input  wire logic             saveEn,   // Capture strobe.
  input  wire logic [WIDTH-1:0] saveData, // Word to capture.
  output logic      [WIDTH-1:0] savedWord // Captured word, from a register.
);
  import bcdc_pkg::*;

  logic [WIDTH-1:0] word_d;

  ////////////////////////////////////////////////////////////////////////
  // Keep the old copy unless a new entry captures over it.
  always_comb begin
    word_d = savedWord;
    if (saveEn) begin
      word_d = saveData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      savedWord <= CTRL_RESET[WIDTH-1:0];
    end else begin
      savedWord <= word_d;
    end
  end

endmodule // bcdc_save_store

// ### design/bcdc_debug_ctl.sv
`timescale 1ns/1ps
// Summary of operation
// - Record enable on: push taken branches, interrupts, non-debug exceptions to records.
// - Debug exception clears record enable; stored records stay untouched.
// - Step-on-branch with trap flag: single-step trap only after branching instructions.
// - Any debug exception clears the step-on-branch control.
// - Message enable on: send a branch trace message per taken branch, interrupt, non-debug exception.
// - Store enable on: log branch trace messages into the memory trace buffer.
// - Store interrupt enable: interrupt when buffer full, else wrap the buffer.
// - Skip-privileged set: no trace store or message at privilege level zero.
// - Skip-user set: no trace store or message above privilege level zero.
// - Hold-records set: freeze branch records on a counter overflow interrupt.
// - Hold-counters set: freeze all performance counters on counter overflow interrupt.
// - Management hold: on entry clear counter enables, save control, clear four enables.
// - Management return: set counter enables and restore the saved control word.
// - Workload history is reset on held entry and on return, if classification on.
// - Transaction debugging enabled only with control bit 15 and breakpoint bit both set.
// - Debug exception keeps message enable; records may update while messages enabled.
// - Both transaction controls: debug abort resumes at begin and raises debug exception.
module bcdc_debug_ctl #(
  parameter bit MSG_KEEPS_RECORDS = 1'b1
) (
  input  wire logic                  core_clk,          // Core clock, 20 MHz.
  input  wire logic                  nrst,              // Synchronous reset, active low.
  input  wire logic                  msrWrEn,           // Register write strobe.
  input  wire logic                  msrRdEn,           // Register read strobe.
  input  wire logic [31:0]           msrAddr,           // Register address.
  input  wire logic [63:0]           msrWrData,         // Write data.
  output logic      [63:0]           msrRdData,         // Read data, registered.
  output logic                       msrRdValid,        // Read data valid pulse.
  output logic                       msrAccessFault,    // Unmapped access pulse.
  input  wire bcdc_pkg::bcdc_evt_s   evt,               // Core event pulses.
  input  wire logic                  trapStepFlag,      // Trap step flag of the flags word.
  input  wire logic [1:0]            privilegeLevel,    // Current privilege level.
  input  wire logic                  counterOverflowIrq, // Counter overflow interrupt request.
  input  wire logic                  mgmtIrqDeliver,    // Management interrupt delivered.
  input  wire logic                  mgmtReturn,        // Management return executed.
  input  wire logic                  wlcEnable,         // Workload classification enabled.
  input  wire logic                  traceBufFull,      // Trace buffer has no free slot.
  input  wire logic                  bpTxDebug,         // Breakpoint-control transaction bit.
  input  wire logic                  txAbortDebug,      // Abort by debug or breakpoint trap.
  output bcdc_pkg::bcdc_pulse_s      pulses,            // One-cycle requests to the core.
  output logic                       recordsFrozen,     // Branch records frozen.
  output logic                       countersFrozen,    // Performance counters frozen.
  output logic                       txDebugEnabled,    // Transaction debugging active.
  output logic                       inMgmtHold,        // Saved control awaiting return.
  output logic      [63:0]           debugControl       // Current control word.
);
  import bcdc_pkg::*;

  logic [63:0]  ctrl_d;
  logic [63:0]  ctrl_q;
  bcdc_mode_e   mode_d;
  bcdc_mode_e   mode_q;
  logic         recFrz_d;
  logic         recFrz_q;
  logic         cntFrz_d;
  logic         cntFrz_q;
  logic         txEn_d;
  logic         txEn_q;
  logic [63:0]  rdData_d;
  logic [63:0]  rdData_q;
  logic         rdValid_d;
  logic         rdValid_q;
  logic         fault_d;
  logic         fault_q;
  logic [63:0]  savedCtrl;
  logic         saveNow;
  logic         restoreNow;
  logic         addrHit;
  logic         ctrlWrite;
  logic         traceEvent;
  logic         traceAllowed;
  bcdc_pulse_s  pulse_d;

  ////////////////////////////////////////////////////////////////////////
  // Register access decode.
  assign addrHit   = (msrAddr == BCDC_CTRL_ADDR);
  assign ctrlWrite = msrWrEn && addrHit;

  // Management entry saves only when the hold control is on; return restores only
  // a copy that was really taken, so a stray return cannot load stale state.
  assign saveNow    = mgmtIrqDeliver && ctrl_q[BIT_HOLD_MGMT];
  assign restoreNow = mgmtReturn && (mode_q == MODE_HELD);

  ////////////////////////////////////////////////////////////////////////
  // Control word next value. Software write lands first, then restore, then the
  // hardware clears, so a clear raised in the same cycle as a write is never lost.
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrlWrite) begin
      ctrl_d = msrWrData & CTRL_WR_MASK;
    end
    if (restoreNow) begin
      ctrl_d = savedCtrl & CTRL_WR_MASK;
    end
    if (saveNow) begin
      ctrl_d = ctrl_d & ~CTRL_MGMT_CLR;
    end
    if (evt.debugExcRaise) begin
      // Message enable is left alone on a debug exception.
      ctrl_d = ctrl_d & ~CTRL_DBG_CLR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Saved copy of the control word taken at management entry.
  bcdc_save_store #(
    .WIDTH (BCDC_CTRL_W)
  ) u_save (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .saveEn    (saveNow),
    .saveData  (ctrl_q),
    .savedWord (savedCtrl)
  );

  ////////////////////////////////////////////////////////////////////////
  // Management mode tracking: held from a saving entry until its return.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RUN: begin
        if (saveNow) begin
          mode_d = MODE_HELD;
        end
      end
      MODE_HELD: begin
        if (mgmtReturn) begin
          mode_d = MODE_RUN;
        end
      end
      default: begin
        mode_d = MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode_q <= MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Freeze flags. An overflow request sets each one whose hold control is on; any control write releases
  // them. Set wins over the release when both come in the same cycle.
  always_comb begin
    recFrz_d = recFrz_q;
    cntFrz_d = cntFrz_q;
    if (ctrlWrite) begin
      recFrz_d = 1'b0;
      cntFrz_d = 1'b0;
    end
    if (counterOverflowIrq && ctrl_q[BIT_HOLD_REC]) begin
      recFrz_d = 1'b1;
    end
    if (counterOverflowIrq && ctrl_q[BIT_HOLD_CNT]) begin
      cntFrz_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      recFrz_q <= 1'b0;
      cntFrz_q <= 1'b0;
    end else begin
      recFrz_q <= recFrz_d;
      cntFrz_q <= cntFrz_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transaction debug enable follows both controls with one cycle of latency.
  always_comb begin
    txEn_d = ctrl_q[BIT_TX_DEBUG] && bpTxDebug;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      txEn_q <= 1'b0;
    end else begin
      txEn_q <= txEn_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trace qualification. Debug exceptions are never recorded or traced, and
  // the privilege filters cover both stores and messages.
  assign traceEvent = evt.branchTaken || evt.intrTaken ||
                      (evt.excTaken && !evt.excIsDebug);
  assign traceAllowed =
      !(ctrl_q[BIT_SKIP_PRIV] && (privilegeLevel == PRIV_KERNEL)) &&
      !(ctrl_q[BIT_SKIP_USER] && (privilegeLevel != PRIV_KERNEL));

  ////////////////////////////////////////////////////////////////////////
  // Request pulses for the core, registered in the pulse stage below.
  always_comb begin
    pulse_d = '0;
    // Record pushes also run under message enable on cores that build messages
    // from the record stack; the parameter picks that behaviour.
    pulse_d.recordPush = traceEvent && !recFrz_q &&
                         (ctrl_q[BIT_REC_EN] ||
                          (MSG_KEEPS_RECORDS && ctrl_q[BIT_MSG_EN]));
    pulse_d.traceMsgSend    = traceEvent && traceAllowed && ctrl_q[BIT_MSG_EN];
    pulse_d.traceStoreWrite = traceEvent && traceAllowed && ctrl_q[BIT_STORE_EN];
    // A store into a full buffer either interrupts or wraps the write pointer.
    pulse_d.traceStoreIrq  = pulse_d.traceStoreWrite && traceBufFull &&
                             ctrl_q[BIT_STORE_IRQ];
    pulse_d.traceStoreWrap = pulse_d.traceStoreWrite && traceBufFull &&
                             !ctrl_q[BIT_STORE_IRQ];
    // Step-on-branch narrows the trap to instructions that branched.
    pulse_d.stepTrapReq = evt.instrRetire && trapStepFlag &&
                          (!ctrl_q[BIT_STEP_BRANCH] || evt.instrIsBranch);
    pulse_d.counterEnClear  = saveNow;
    pulse_d.counterEnSet    = restoreNow;
    pulse_d.wlcHistoryReset = wlcEnable && (saveNow || restoreNow);
    // Abort under active transaction debugging returns to the begin op with a
    // debug exception; otherwise the core takes the fallback address.
    pulse_d.txResumeAtBegin = txAbortDebug && txEn_q;
    pulse_d.txDebugExcReq   = txAbortDebug && txEn_q;
    pulse_d.txFallback      = txAbortDebug && !txEn_q;
  end

  bcdc_pulse_reg #(
    .WIDTH ($bits(bcdc_pulse_s))
  ) u_pulse (
    .core_clk (core_clk),
    .nrst     (nrst),
    .dIn      (pulse_d),
    .qOut     (pulses)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register read path. Reserved bits are already zero in the stored word.
  always_comb begin
    rdData_d  = rdData_q;
    rdValid_d = 1'b0;
    fault_d   = 1'b0;
    if (msrRdEn && addrHit) begin
      rdData_d  = ctrl_q;
      rdValid_d = 1'b1;
    end
    if ((msrRdEn || msrWrEn) && !addrHit) begin
      fault_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdData_q  <= CTRL_RESET;
      rdValid_q <= 1'b0;
      fault_q   <= 1'b0;
    end else begin
      rdData_q  <= rdData_d;
      rdValid_q <= rdValid_d;
      fault_q   <= fault_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops; inMgmtHold is a compare on mode_q.
  assign msrRdData      = rdData_q;
  assign msrRdValid     = rdValid_q;
  assign msrAccessFault = fault_q;
  assign recordsFrozen  = recFrz_q;
  assign countersFrozen = cntFrz_q;
  assign txDebugEnabled = txEn_q;
  assign inMgmtHold     = (mode_q == MODE_HELD);
  assign debugControl   = ctrl_q;

endmodule // bcdc_debug_ctl

// ### dv/bcdc_debug_ctl_monitor.sv
`timescale 1ns/1ps
// Port-level checker for the debug control block; it sees only the top ports.
module bcdc_debug_ctl_monitor
  import bcdc_pkg::*;
(
  input wire logic                  core_clk,           // Core clock.
  input wire logic                  nrst,               // Reset, active low.
  input wire logic                  msrWrEn,            // Write strobe.
  input wire logic                  msrRdEn,            // Read strobe.
  input wire logic [31:0]           msrAddr,            // Address.
  input wire logic [63:0]           msrWrData,          // Write data.
  input wire logic [63:0]           msrRdData,          // Read data.
  input wire logic                  msrRdValid,         // Read valid.
  input wire logic                  msrAccessFault,     // Unmapped access.
  input wire bcdc_pkg::bcdc_evt_s   evt,                // Core events.
  input wire logic                  trapStepFlag,       // Trap step flag.
  input wire logic [1:0]            privilegeLevel,     // Privilege level.
  input wire logic                  counterOverflowIrq, // Overflow request.
  input wire logic                  mgmtIrqDeliver,     // Management entry.
  input wire logic                  mgmtReturn,         // Management return.
  input wire logic                  wlcEnable,          // Classification on.
  input wire logic                  traceBufFull,       // Buffer full.
  input wire logic                  bpTxDebug,          // Breakpoint tx bit.
  input wire logic                  txAbortDebug,       // Debug abort.
  input wire bcdc_pkg::bcdc_pulse_s pulses,             // Request pulses.
  input wire logic                  recordsFrozen,      // Records frozen.
  input wire logic                  countersFrozen,     // Counters frozen.
  input wire logic                  txDebugEnabled,     // Tx debug active.
  input wire logic                  inMgmtHold,         // Saved copy held.
  input wire logic [63:0]           debugControl        // Control word.
);
  // One clock domain, so clocking and reset qualification are given once.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // Event responses one cycle after their cause.
  a_rec_push_on: assert property (
    (evt.branchTaken && debugControl[BIT_REC_EN] && !recordsFrozen) |=> pulses.recordPush)
    else $error("record push missing");
  a_dbg_clear_en: assert property (
    evt.debugExcRaise |=> debugControl[1:0] == 2'h0) else $error("enables not cleared");
  a_dbg_keep_msg: assert property (
    (evt.debugExcRaise && debugControl[BIT_MSG_EN] && !msrWrEn && !mgmtIrqDeliver
     && !mgmtReturn) |=> debugControl[BIT_MSG_EN]) else $error("message enable lost");
  a_step_branch_only: assert property (
    (evt.instrRetire && trapStepFlag && debugControl[BIT_STEP_BRANCH])
    |=> pulses.stepTrapReq == $past(evt.instrIsBranch)) else $error("bad step trap");
  a_skip_priv: assert property (
    (debugControl[BIT_SKIP_PRIV] && privilegeLevel == PRIV_KERNEL)
    |=> !(pulses.traceMsgSend || pulses.traceStoreWrite)) else $error("trace not skipped");
  a_store_full: assert property (
    (pulses.traceStoreWrite && $past(traceBufFull))
    |-> pulses.traceStoreIrq == $past(debugControl[BIT_STORE_IRQ])
    && pulses.traceStoreWrap != $past(debugControl[BIT_STORE_IRQ])) else $error("bad full");
  a_hold_freeze: assert property (
    (counterOverflowIrq && debugControl[BIT_HOLD_REC] && debugControl[BIT_HOLD_CNT])
    |=> recordsFrozen && countersFrozen) else $error("freeze missing");

  ////////////////////////////////////////////////////////////////////////////////
  // Management mode, transactions and reserved space.
  a_mgmt_entry: assert property (
    (mgmtIrqDeliver && debugControl[BIT_HOLD_MGMT]) |=> pulses.counterEnClear
    && inMgmtHold && (debugControl & CTRL_MGMT_CLR) == 64'h0) else $error("bad entry");
  a_mgmt_return: assert property (
    (mgmtReturn && inMgmtHold && !mgmtIrqDeliver) |=> pulses.counterEnSet && !inMgmtHold)
    else $error("bad return");
  a_tx_abort: assert property (
    txAbortDebug |=> pulses.txResumeAtBegin == $past(txDebugEnabled)
    && pulses.txFallback == !$past(txDebugEnabled)) else $error("bad abort path");
  a_rsvd_zero: assert property (
    (debugControl & ~CTRL_WR_MASK) == 64'h0) else $error("reserved bit set");
endmodule // bcdc_debug_ctl_monitor

bind bcdc_debug_ctl bcdc_debug_ctl_monitor u_mon (
  .core_clk(core_clk), .nrst(nrst), .msrWrEn(msrWrEn), .msrRdEn(msrRdEn),
  .msrAddr(msrAddr), .msrWrData(msrWrData), .msrRdData(msrRdData),
  .msrRdValid(msrRdValid), .msrAccessFault(msrAccessFault), .evt(evt),
  .trapStepFlag(trapStepFlag), .privilegeLevel(privilegeLevel),
  .counterOverflowIrq(counterOverflowIrq), .mgmtIrqDeliver(mgmtIrqDeliver),
  .mgmtReturn(mgmtReturn), .wlcEnable(wlcEnable), .traceBufFull(traceBufFull),
  .bpTxDebug(bpTxDebug), .txAbortDebug(txAbortDebug), .pulses(pulses),
  .recordsFrozen(recordsFrozen), .countersFrozen(countersFrozen),
  .txDebugEnabled(txDebugEnabled), .inMgmtHold(inMgmtHold), .debugControl(debugControl)
);

// ### dv/tb_top.sv
`timescale 1ns/1ps
// Directed bench: a table of event cases, then hand-written awkward cases.
module tb_top;
  import bcdc_pkg::*;

  // One ordinary case: control word, levels and event beside the expected pulses.
  typedef struct packed {
    logic [15:0] ctl;
    logic [1:0]  pl;
    logic        full;
    logic        trap;
    bcdc_evt_s   ev;
    bcdc_pulse_s exp;
  } bcdc_row_s;

  localparam bcdc_row_s ROWS [11] = '{
    '{16'h0001, 2'h3, 1'b0, 1'b0, 7'h40, 12'h800},
    '{16'h0001, 2'h3, 1'b0, 1'b0, 7'h10, 12'h800},
    '{16'h0001, 2'h3, 1'b0, 1'b0, 7'h18, 12'h000},
    '{16'h0040, 2'h3, 1'b0, 1'b0, 7'h40, 12'hC00},
    '{16'h0080, 2'h3, 1'b1, 1'b0, 7'h20, 12'h280},
    '{16'h0180, 2'h3, 1'b1, 1'b0, 7'h20, 12'h300},
    '{16'h02C0, 2'h0, 1'b0, 1'b0, 7'h40, 12'h800},
    '{16'h02C0, 2'h3, 1'b0, 1'b0, 7'h40, 12'hE00},
    '{16'h04C0, 2'h2, 1'b0, 1'b0, 7'h40, 12'h800},
    '{16'h0002, 2'h3, 1'b0, 1'b1, 7'h04, 12'h000},
    '{16'h0002, 2'h3, 1'b0, 1'b1, 7'h06, 12'h040}
  };

  logic        core_clk, nrst, msrWrEn, msrRdEn, trapStepFlag, wlcEnable, traceBufFull;
  logic        counterOverflowIrq, mgmtIrqDeliver, mgmtReturn, txAbortDebug, bpTxDebug;
  logic        msrRdValid, msrAccessFault, recordsFrozen, countersFrozen;
  logic        txDebugEnabled, inMgmtHold;
  logic [1:0]  privilegeLevel;
  logic [31:0] msrAddr;
  logic [63:0] msrWrData, msrRdData, debugControl;
  logic [3:0]  flags;
  bcdc_evt_s   evt;
  bcdc_pulse_s pulses;
  int          n_fail = 0;
  int          checks_done = 0;

  assign flags = {recordsFrozen, countersFrozen, txDebugEnabled, inMgmtHold};

  bcdc_debug_ctl #(.MSG_KEEPS_RECORDS(1'b1)) uut (
    .core_clk(core_clk), .nrst(nrst), .msrWrEn(msrWrEn), .msrRdEn(msrRdEn),
    .msrAddr(msrAddr), .msrWrData(msrWrData), .msrRdData(msrRdData),
    .msrRdValid(msrRdValid), .msrAccessFault(msrAccessFault), .evt(evt),
    .trapStepFlag(trapStepFlag), .privilegeLevel(privilegeLevel),
    .counterOverflowIrq(counterOverflowIrq), .mgmtIrqDeliver(mgmtIrqDeliver),
    .mgmtReturn(mgmtReturn), .wlcEnable(wlcEnable), .traceBufFull(traceBufFull),
    .bpTxDebug(bpTxDebug), .txAbortDebug(txAbortDebug), .pulses(pulses),
    .recordsFrozen(recordsFrozen), .countersFrozen(countersFrozen),
    .txDebugEnabled(txDebugEnabled), .inMgmtHold(inMgmtHold), .debugControl(debugControl)
  );

  // Clock of 50 ns; inputs move on the falling edge, away from sampling.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and bus tasks; every task starts and ends just after a falling edge.
  task automatic note(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    note(got === exp, "word mismatch");
  endtask
  task automatic chk_pul(input bcdc_pulse_s got, input bcdc_pulse_s exp);
    note(got === exp, "pulse mismatch");
  endtask
  task automatic chk_flg(input logic [3:0] got, input logic [3:0] exp);
    note(got === exp, "flag mismatch");
  endtask
  task automatic wr(input logic [63:0] d);
    msrWrEn   = 1'b1;
    msrAddr   = BCDC_CTRL_ADDR;
    msrWrData = d;
    @(negedge core_clk);
    msrWrEn = 1'b0;
  endtask
  // Reads answer one cycle after the strobe; valid pulses for that cycle only, the data holds until the next read of the control address.
  task automatic rd(input logic [31:0] a, input logic [63:0] exp);
    msrRdEn = 1'b1;
    msrAddr = a;
    @(negedge core_clk);
    msrRdEn = 1'b0;
    chk_flg({2'h0, msrRdValid, msrAccessFault}, {2'h0, a == BCDC_CTRL_ADDR, a != BCDC_CTRL_ADDR});
    if (a == BCDC_CTRL_ADDR) chk_word(msrRdData, exp);
  endtask
  // Side pulses: overflow, management entry, management return, debug abort.
  task automatic fire(input bcdc_evt_s e, input logic [3:0] s);
    evt = e;
    {counterOverflowIrq, mgmtIrqDeliver, mgmtReturn, txAbortDebug} = s;
    @(negedge core_clk);
    evt = '0;
    {counterOverflowIrq, mgmtIrqDeliver, mgmtReturn, txAbortDebug} = 4'h0;
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {nrst, msrWrEn, msrRdEn, trapStepFlag, wlcEnable, traceBufFull, bpTxDebug} = '0;
    {counterOverflowIrq, mgmtIrqDeliver, mgmtReturn, txAbortDebug} = 4'h0;
    {privilegeLevel, msrAddr, msrWrData, evt} = '0;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    rd(BCDC_CTRL_ADDR, 64'h0);
    foreach (ROWS[i]) begin
      wr({48'h0, ROWS[i].ctl});
      {privilegeLevel, traceBufFull, trapStepFlag} = {ROWS[i].pl, ROWS[i].full, ROWS[i].trap};
      fire(ROWS[i].ev, 4'h0);
      chk_pul(pulses, ROWS[i].exp);
    end
    {traceBufFull, trapStepFlag} = 2'h0;
    wr(64'hFFFF_FFFF_FFFF_FFFF);
    rd(BCDC_CTRL_ADDR, 64'h0000_0000_0000_DFC3);
    // Let an edge pass so the read strobe is not lowered and raised in one step.
    @(negedge core_clk);
    rd(32'h0000_01DA, 64'h0);
    // A debug exception drops recording and stepping but keeps messages.
    wr(64'h0000_0000_0000_00C3);
    fire(7'h01, 4'h0);
    chk_word(debugControl, 64'h0000_0000_0000_00C0);
    // The debugger re-arms step-on-branch before resuming; a plain retire must not trap.
    wr(64'h0000_0000_0000_00C2);
    trapStepFlag = 1'b1;
    fire(7'h04, 4'h0);
    chk_pul(pulses, 12'h000);
    trapStepFlag = 1'b0;
    // Freeze on overflow blocks record pushes while messages still go out.
    wr(64'h0000_0000_0000_1841);
    fire(7'h00, 4'h8);
    chk_flg(flags, 4'hC);
    // One idle edge keeps the event pulses of the two calls apart.
    @(negedge core_clk);
    fire(7'h40, 4'h0);
    chk_pul(pulses, 12'h400);
    wr(64'h0000_0000_0000_0001);
    fire(7'h00, 4'h8);
    chk_flg(flags, 4'h0);
    // Management entry saves the word; a handler write is undone on return.
    wlcEnable = 1'b1;
    wr(64'h0000_0000_0000_40C3);
    fire(7'h00, 4'h4);
    chk_pul(pulses, 12'h028);
    chk_word(debugControl, 64'h0000_0000_0000_4000);
    chk_flg(flags, 4'h1);
    wr(64'h0000_0000_0000_4400);
    fire(7'h00, 4'h2);
    chk_pul(pulses, 12'h018);
    chk_word(debugControl, 64'h0000_0000_0000_40C3);
    // A second return, two edges after the first, finds no held copy and restores nothing.
    @(negedge core_clk);
    fire(7'h00, 4'h2);
    chk_pul(pulses, 12'h000);
    wr(64'h0000_0000_0000_00C3);
    fire(7'h00, 4'h4);
    chk_word(debugControl, 64'h0000_0000_0000_00C3);
    // Transaction debug needs both controls; otherwise the fallback is taken.
    wr(64'h0000_0000_0000_8000);
    bpTxDebug = 1'b1;
    @(negedge core_clk);
    chk_flg(flags, 4'h2);
    fire(7'h00, 4'h1);
    chk_pul(pulses, 12'h006);
    bpTxDebug = 1'b0;
    @(negedge core_clk);
    fire(7'h00, 4'h1);
    chk_pul(pulses, 12'h001);
    // A second reset in mid-run clears the word again.
    nrst = 1'b0;
    @(negedge core_clk);
    nrst = 1'b1;
    chk_word(debugControl, 64'h0);
    wrap_up();
  end

  // Watchdog far beyond the directed sequence length.
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    $display("[ERR] %0t run did not finish", $time);
    wrap_up();
  end
endmodule // tb_top
